/* File: core/core_register_file_latency.sv */
// program-accessible register file with peripheral write-to-read latency
`timescale 1ns/100ps

module core_register_file_latency
  import regfile_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr_en_i,
  input  wire logic [4:0]  wr_sel_i,
  input  wire logic [2:0]  wr_idx_i,
  input  wire logic [39:0] wr_data_i,
  input  wire logic        rd_en_i,
  input  wire logic [4:0]  rd_sel_i,
  input  wire logic [2:0]  rd_idx_i,
  input  wire logic        pc_adv_i,
  input  wire logic        pc_load_i,
  input  wire logic [19:0] pc_target_i,
  input  wire logic [19:0] addr_base_i,
  input  wire logic [1:0]  step_sel_i,
  output logic [39:0]      rd_data_o,
  output logic             rd_err_o,
  output logic             wr_err_o,
  output logic             cmd_valid_o,
  output logic             cmd_unit_o,
  output logic [15:0]      cmd_data_o,
  output logic [19:0]      pc_o,
  output logic [19:0]      next_addr_o
);

  logic [39:0] acc_q [8];
  logic [15:0] waitflag_q, csave_hi_q, cstate_q, iocfg_q, cnt_hold_q;
  logic [15:0] aux_q [4];
  logic [15:0] auc_q [2];
  logic [15:0] loopcnt_q [2];
  logic [15:0] csave_lo_q;
  logic [19:0] xstep_a_q, xstep_b_q, ystep_a_q, ystep_b_q, intstat_q;
  logic [19:0] intctl_q [2];
  logic [31:0] mailbox_q;
  logic [15:0] in_wptr_q [2];
  logic [15:0] out_rptr_q [2];
  logic [19:0] pc_q;

  // write pipeline toward the off-core registers
  logic        p1_vld_q, p2_vld_q;
  logic [4:0]  p1_sel_q, p2_sel_q;
  logic        p1_idx_q, p2_idx_q;
  logic [31:0] p1_dat_q, p2_dat_q;

  logic        wr_core, wr_periph, wr_ro;
  logic        p1_iou;
  logic [39:0] rd_val;
  logic        rd_bad;
  logic [19:0] step_val;

  assign wr_ro     = (wr_sel_i == SEL_YOFF_HB) || (wr_sel_i == SEL_YOFF_LB);
  assign wr_periph = wr_en_i && ((wr_sel_i == SEL_IOCFG) || (wr_sel_i == SEL_MAILBOX)
                  || (wr_sel_i == SEL_IN_WPTR) || (wr_sel_i == SEL_OUT_RPTR));
  assign wr_core   = wr_en_i && !wr_periph && !wr_ro;
  assign p1_iou    = (p1_sel_q == SEL_IN_WPTR) || (p1_sel_q == SEL_OUT_RPTR);

  // core registers: written at once
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int n = 0; n < 8; n++) acc_q[n] <= RST_VAL;
      for (int n = 0; n < 4; n++) aux_q[n] <= RST_VAL[15:0];
      for (int n = 0; n < 2; n++) begin
        auc_q[n]     <= RST_VAL[15:0];
        loopcnt_q[n] <= RST_VAL[15:0];
        intctl_q[n]  <= RST_VAL[19:0];
      end
      waitflag_q <= RST_VAL[15:0];
      cnt_hold_q <= RST_VAL[15:0];
      csave_hi_q <= RST_VAL[15:0];
      csave_lo_q <= RST_VAL[15:0];
      cstate_q   <= RST_VAL[15:0];
      xstep_a_q  <= RST_VAL[19:0];
      xstep_b_q  <= RST_VAL[19:0];
      ystep_a_q  <= RST_VAL[19:0];
      ystep_b_q  <= RST_VAL[19:0];
      intstat_q  <= RST_VAL[19:0];
    end else if (wr_core) begin
      unique case (wr_sel_i)
        SEL_ACC_FULL:  acc_q[wr_idx_i] <= wr_data_i;
        SEL_ACC_HI:    acc_q[wr_idx_i][31:HALF_LO] <= wr_data_i[15:0];
        SEL_ACC_LO:    acc_q[wr_idx_i][HALF_LO-1:0] <= wr_data_i[15:0];
        SEL_ACC_GUARD: acc_q[wr_idx_i][ACC_W-1:GUARD_LO] <= wr_data_i[7:0];
        SEL_ACC_VEC: begin
          // lower-numbered accumulator takes the upper word half
          acc_q[{wr_idx_i[1:0], 1'b0}][31:HALF_LO] <= wr_data_i[31:16];
          acc_q[{wr_idx_i[1:0], 1'b1}][31:HALF_LO] <= wr_data_i[15:0];
        end
        SEL_WAITFLAG:  waitflag_q <= wr_data_i[15:0];
        SEL_AUX:       aux_q[wr_idx_i[1:0]] <= wr_data_i[15:0];
        SEL_AUC:       auc_q[wr_idx_i[0]] <= wr_data_i[15:0];
        SEL_LOOPCNT:   loopcnt_q[wr_idx_i[0]] <= wr_data_i[15:0];
        SEL_CNT_HOLD:  cnt_hold_q <= wr_data_i[15:0];
        SEL_CSAVE:     {csave_hi_q, csave_lo_q} <= wr_data_i[31:0];
        SEL_CSTATE:    cstate_q <= wr_data_i[15:0];
        SEL_XSTEP_A:   xstep_a_q <= wr_data_i[19:0];
        SEL_XSTEP_B:   xstep_b_q <= wr_data_i[19:0];
        SEL_INTCTL:    intctl_q[wr_idx_i[0]] <= wr_data_i[19:0];
        SEL_INTSTAT:   intstat_q <= wr_data_i[19:0];
        SEL_YSTEP_A:   ystep_a_q <= wr_data_i[19:0];
        SEL_YSTEP_B:   ystep_b_q <= wr_data_i[19:0];
        default:       ;
      endcase
    end
  end

  // off-core writes travel the pipelined data bus before landing
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_vld_q <= 1'b0;
      p1_sel_q <= SEL_ACC_FULL;
      p1_idx_q <= 1'b0;
      p1_dat_q <= RST_VAL[31:0];
      p2_vld_q <= 1'b0;
      p2_sel_q <= SEL_ACC_FULL;
      p2_idx_q <= 1'b0;
      p2_dat_q <= RST_VAL[31:0];
    end else begin
      p1_vld_q <= wr_periph;
      p1_sel_q <= wr_sel_i;
      p1_idx_q <= wr_idx_i[0];
      p1_dat_q <= wr_data_i[31:0];
      p2_vld_q <= p1_vld_q && p1_iou;
      p2_sel_q <= p1_sel_q;
      p2_idx_q <= p1_idx_q;
      p2_dat_q <= p1_dat_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iocfg_q   <= RST_VAL[15:0];
      mailbox_q <= RST_VAL[31:0];
    end else if (p1_vld_q && !p1_iou) begin
      if (p1_sel_q == SEL_IOCFG) begin
        iocfg_q <= p1_dat_q[15:0];
      end else begin
        mailbox_q <= p1_dat_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int n = 0; n < 2; n++) begin
        in_wptr_q[n]  <= RST_VAL[15:0];
        out_rptr_q[n] <= RST_VAL[15:0];
      end
    end else if (p2_vld_q) begin
      if (p2_sel_q == SEL_IN_WPTR) begin
        in_wptr_q[p2_idx_q] <= p2_dat_q[15:0];
      end else begin
        out_rptr_q[p2_idx_q] <= p2_dat_q[15:0];
      end
    end
  end

  // command writes leave the file as a one-cycle strobe, nothing is stored
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_unit_o  <= 1'b0;
      cmd_data_o  <= RST_VAL[15:0];
    end else begin
      cmd_valid_o <= wr_en_i && (wr_sel_i == SEL_IOCMD);
      cmd_unit_o  <= wr_idx_i[0];
      cmd_data_o  <= wr_data_i[15:0];
    end
  end

  // read mux shows only landed values, so early reads see the old one
  always_comb begin
    rd_val = RST_VAL;
    rd_bad = 1'b0;
    unique case (rd_sel_i)
      SEL_ACC_FULL:  rd_val = acc_q[rd_idx_i];
      SEL_ACC_HI:    rd_val = {{24{acc_q[rd_idx_i][31]}}, acc_q[rd_idx_i][31:16]};
      SEL_ACC_LO:    rd_val = {{24{acc_q[rd_idx_i][15]}}, acc_q[rd_idx_i][15:0]};
      SEL_ACC_GUARD: rd_val = {{32{acc_q[rd_idx_i][39]}}, acc_q[rd_idx_i][39:32]};
      SEL_ACC_VEC:   rd_val = {{8{acc_q[{rd_idx_i[1:0], 1'b0}][31]}},
                               acc_q[{rd_idx_i[1:0], 1'b0}][31:16],
                               acc_q[{rd_idx_i[1:0], 1'b1}][31:16]};
      SEL_WAITFLAG:  rd_val = {24'h00_0000, waitflag_q};
      SEL_AUX:       rd_val = {{24{aux_q[rd_idx_i[1:0]][15]}}, aux_q[rd_idx_i[1:0]]};
      SEL_AUC:       rd_val = {24'h00_0000, auc_q[rd_idx_i[0]]};
      SEL_LOOPCNT:   rd_val = {{24{loopcnt_q[rd_idx_i[0]][15]}}, loopcnt_q[rd_idx_i[0]]};
      SEL_CNT_HOLD:  rd_val = {{24{cnt_hold_q[15]}}, cnt_hold_q};
      SEL_CSAVE:     rd_val = {8'h00, csave_hi_q, csave_lo_q};
      SEL_CSTATE:    rd_val = {24'h00_0000, cstate_q};
      SEL_XSTEP_A:   rd_val = {{20{xstep_a_q[19]}}, xstep_a_q};
      SEL_XSTEP_B:   rd_val = {{20{xstep_b_q[19]}}, xstep_b_q};
      SEL_IOCFG:     rd_val = {24'h00_0000, iocfg_q};
      SEL_INTCTL:    rd_val = {20'h0_0000, intctl_q[rd_idx_i[0]]};
      SEL_INTSTAT:   rd_val = {20'h0_0000, intstat_q};
      SEL_YSTEP_A:   rd_val = {{20{ystep_a_q[19]}}, ystep_a_q};
      SEL_YOFF_HB:   rd_val = {32'h0000_0000, ystep_a_q[15:8]};
      SEL_YOFF_LB:   rd_val = {32'h0000_0000, ystep_a_q[7:0]};
      SEL_MAILBOX:   rd_val = {8'h00, mailbox_q};
      SEL_YSTEP_B:   rd_val = {{20{ystep_b_q[19]}}, ystep_b_q};
      SEL_IN_WPTR:   rd_val = {24'h00_0000, in_wptr_q[rd_idx_i[0]]};
      SEL_OUT_RPTR:  rd_val = {24'h00_0000, out_rptr_q[rd_idx_i[0]]};
      SEL_IOCMD:     rd_bad = 1'b1;
      // port data and program counter have no selector at all
      default:       rd_bad = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= RST_VAL;
      rd_err_o  <= 1'b0;
      wr_err_o  <= 1'b0;
    end else begin
      rd_err_o <= rd_en_i && rd_bad;
      wr_err_o <= wr_en_i && (wr_ro || (wr_sel_i > SEL_OUT_RPTR));
      if (rd_en_i) begin
        rd_data_o <= rd_bad ? RST_VAL : rd_val;
      end
    end
  end

  // sequencer-owned program counter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q <= RST_VAL[19:0];
    end else if (pc_load_i) begin
      pc_q <= pc_target_i;
    end else if (pc_adv_i) begin
      pc_q <= pc_q + 20'h0_0001;
    end
  end
  assign pc_o = pc_q;

  always_comb begin
    unique case (step_sel_i)
      2'h0:    step_val = xstep_a_q;
      2'h1:    step_val = xstep_b_q;
      2'h2:    step_val = ystep_a_q;
      default: step_val = ystep_b_q;
    endcase
  end

  // two's complement add wraps within the address width
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      next_addr_o <= RST_VAL[19:0];
    end else begin
      next_addr_o <= addr_base_i + step_val;
    end
  end

  // back-to-back writes are legal; the one still in flight would land inside the window
  chk_periph_write_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_IOCFG && !(p1_vld_q && p1_sel_q == SEL_IOCFG))
      |=> (iocfg_q == $past(iocfg_q)) ##1 (iocfg_q == $past(wr_data_i[15:0], 2)))
    else $error("io config write landed at the wrong cycle");

  chk_iou_ptr_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_IN_WPTR && wr_idx_i == 3'h0
      && !(p1_vld_q && p1_sel_q == SEL_IN_WPTR && !p1_idx_q)
      && !(p2_vld_q && p2_sel_q == SEL_IN_WPTR && !p2_idx_q))
      |=> $stable(in_wptr_q[0]) ##1 $stable(in_wptr_q[0])
      ##1 (in_wptr_q[0] == $past(wr_data_i[15:0], 3)))
    else $error("input write pointer landed at the wrong cycle");

  chk_cmd_strobe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_IOCMD)
      |=> cmd_valid_o && cmd_data_o == $past(wr_data_i[15:0]) ##1 !cmd_valid_o || $past(wr_en_i))
    else $error("command write not forwarded");

  chk_cmd_unreadable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en_i && rd_sel_i == SEL_IOCMD) |=> rd_err_o && rd_data_o == RST_VAL)
    else $error("command register was readable");

  chk_pc_advance: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pc_adv_i && !pc_load_i) |=> pc_o == $past(pc_o) + 20'h0_0001)
    else $error("program counter did not advance by one");

  chk_vector_halves: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_ACC_VEC && wr_idx_i[1:0] == 2'h1)
      |=> acc_q[2][31:16] == $past(wr_data_i[31:16]) && acc_q[3][31:16] == $past(wr_data_i[15:0])
          && acc_q[2][15:0] == $past(acc_q[2][15:0]))
    else $error("vector write did not update both halves");

  chk_guard_part: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_ACC_GUARD && wr_idx_i == 3'h5)
      |=> acc_q[5][39:32] == $past(wr_data_i[7:0]) && acc_q[5][31:0] == $past(acc_q[5][31:0]))
    else $error("guard write touched wrong bits");

  chk_yoff_byte: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en_i && rd_sel_i == SEL_YOFF_HB) |=> rd_data_o == {32'h0000_0000, $past(ystep_a_q[15:8])})
    else $error("y offset upper byte view wrong");

  chk_next_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (step_sel_i == 2'h2) |=> next_addr_o == $past(addr_base_i) + $past(ystep_a_q))
    else $error("next address not base plus step");

  chk_aux_sign: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en_i && rd_sel_i == SEL_AUX) |=> rd_data_o[39:16] == {24{rd_data_o[15]}})
    else $error("signed read not sign extended");

  chk_mailbox_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_MAILBOX && !(p1_vld_q && p1_sel_q == SEL_MAILBOX))
      |=> (mailbox_q == $past(mailbox_q)) ##1 (mailbox_q == $past(wr_data_i[31:0], 2)))
    else $error("mailbox write landed at the wrong cycle");

  chk_out_ptr_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_OUT_RPTR && wr_idx_i[0]
      && !(p1_vld_q && p1_sel_q == SEL_OUT_RPTR && p1_idx_q)
      && !(p2_vld_q && p2_sel_q == SEL_OUT_RPTR && p2_idx_q))
      |=> $stable(out_rptr_q[1]) ##1 $stable(out_rptr_q[1])
      ##1 (out_rptr_q[1] == $past(wr_data_i[15:0], 3)))
    else $error("output read pointer landed at the wrong cycle");

  chk_byte_view_ro: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && (wr_sel_i == SEL_YOFF_HB || wr_sel_i == SEL_YOFF_LB))
      |=> wr_err_o && $stable(ystep_a_q))
    else $error("byte view write was not refused");

  chk_pc_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pc_load_i |=> pc_o == $past(pc_target_i))
    else $error("program counter did not take the target");

  chk_core_immediate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_ACC_FULL && wr_idx_i == 3'h3)
      |=> acc_q[3] == $past(wr_data_i))
    else $error("accumulator write did not land at once");

  chk_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en_i && rd_sel_i > SEL_OUT_RPTR) |=> rd_err_o && rd_data_o == RST_VAL)
    else $error("unmapped selector was readable");

  chk_cmd_unit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_IOCMD) |=> cmd_unit_o == $past(wr_idx_i[0]))
    else $error("command went to the wrong unit");

  chk_guard_sign: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en_i && rd_sel_i == SEL_ACC_GUARD) |=> rd_data_o[39:8] == {32{rd_data_o[7]}})
    else $error("guard read not sign extended");

  chk_loopcnt_sign: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en_i && rd_sel_i == SEL_LOOPCNT) |=> rd_data_o[39:16] == {24{rd_data_o[15]}})
    else $error("counter read not sign extended");

  cov_iou_readback: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_OUT_RPTR) ##3 (rd_en_i && rd_sel_i == SEL_OUT_RPTR));
  cov_periph_early_read: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_MAILBOX) ##1 (rd_en_i && rd_sel_i == SEL_MAILBOX));
  cov_cmd_write: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) cmd_valid_o);
  cov_vector_write: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_i && wr_sel_i == SEL_ACC_VEC);
  cov_ptr_early_read: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en_i && wr_sel_i == SEL_IN_WPTR) ##1 (rd_en_i && rd_sel_i == SEL_IN_WPTR));

endmodule : core_register_file_latency

/* File: core/regfile_pkg.sv */
// constants shared by the program-accessible register file
package regfile_pkg;
  // register class selectors on the instruction access port
  localparam logic [4:0] SEL_ACC_FULL  = 5'h00;
  localparam logic [4:0] SEL_ACC_HI    = 5'h01;
  localparam logic [4:0] SEL_ACC_LO    = 5'h02;
  localparam logic [4:0] SEL_ACC_GUARD = 5'h03;
  localparam logic [4:0] SEL_ACC_VEC   = 5'h04;
  localparam logic [4:0] SEL_WAITFLAG  = 5'h05;
  localparam logic [4:0] SEL_AUX       = 5'h06;
  localparam logic [4:0] SEL_AUC       = 5'h07;
  localparam logic [4:0] SEL_LOOPCNT   = 5'h08;
  localparam logic [4:0] SEL_CNT_HOLD  = 5'h09;
  localparam logic [4:0] SEL_CSAVE     = 5'h0A;
  localparam logic [4:0] SEL_CSTATE    = 5'h0B;
  localparam logic [4:0] SEL_XSTEP_A   = 5'h0C;
  localparam logic [4:0] SEL_XSTEP_B   = 5'h0D;
  localparam logic [4:0] SEL_IOCFG     = 5'h0E;
  localparam logic [4:0] SEL_INTCTL    = 5'h0F;
  localparam logic [4:0] SEL_INTSTAT   = 5'h10;
  localparam logic [4:0] SEL_YSTEP_A   = 5'h11;
  localparam logic [4:0] SEL_YOFF_HB   = 5'h12;
  localparam logic [4:0] SEL_YOFF_LB   = 5'h13;
  localparam logic [4:0] SEL_MAILBOX   = 5'h14;
  localparam logic [4:0] SEL_YSTEP_B   = 5'h15;
  localparam logic [4:0] SEL_IOCMD     = 5'h16;
  localparam logic [4:0] SEL_IN_WPTR   = 5'h17;
  localparam logic [4:0] SEL_OUT_RPTR  = 5'h18;

  // field positions and widths
  localparam int ACC_W    = 40;
  localparam int GUARD_LO = 32;
  localparam int HALF_LO  = 16;
  localparam int STEP_W   = 20;
  localparam int PC_W     = 20;

  // write-to-read delays of off-core registers, in instruction cycles
  localparam int PERIPH_LAT = 1;
  localparam int IOU_LAT    = 2;

  // every register clears to zero
  localparam logic [39:0] RST_VAL = 40'h00_0000_0000;
endpackage : regfile_pkg

/* File: dv/test_core_register_file_latency.sv */
// self-checking bench for the register file and its off-core read latency
`timescale 1ns/100ps
module test_core_register_file_latency
  import regfile_pkg::*;
;
  logic        sys_clk_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic        wr_en_i     = 1'b0;
  logic [4:0]  wr_sel_i    = 5'h00;
  logic [2:0]  wr_idx_i    = 3'h0;
  logic [39:0] wr_data_i   = 40'h00_0000_0000;
  logic        rd_en_i     = 1'b0;
  logic [4:0]  rd_sel_i    = 5'h00;
  logic [2:0]  rd_idx_i    = 3'h0;
  logic        pc_adv_i    = 1'b0;
  logic        pc_load_i   = 1'b0;
  logic [19:0] pc_target_i = 20'h00000;
  logic [19:0] addr_base_i = 20'h00010;
  logic [1:0]  step_sel_i  = 2'h0;
  logic [39:0] rd_data_o;
  logic        rd_err_o;
  logic        wr_err_o;
  logic        cmd_valid_o;
  logic        cmd_unit_o;
  logic [15:0] cmd_data_o;
  logic [19:0] pc_o;
  logic [19:0] next_addr_o;
  int          bad_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  logic [19:0] addr_exp [4] = '{20'h0000E, 20'h00015, 20'h8A56A, 20'h00011};
  // high bits of the write data are junk on purpose: narrow registers keep the low bits
  logic [4:0]  reg_sel [10] = '{SEL_WAITFLAG, SEL_AUC, SEL_LOOPCNT, SEL_CNT_HOLD, SEL_CSAVE,
                                SEL_CSTATE, SEL_XSTEP_B, SEL_INTCTL, SEL_INTSTAT, SEL_YSTEP_B};
  logic [39:0] reg_dat [10] = '{40'hAB_CDEF_9001, 40'hAB_CDEF_8002, 40'hAB_CDEF_8003,
                                40'hAB_CDEF_8004, 40'hAB_8765_4321, 40'hAB_CDEF_8006,
                                40'hAB_CDE8_0009, 40'hAB_CDE9_8007, 40'hAB_CDEF_8008,
                                40'hAB_CDE8_000A};
  logic [39:0] reg_exp [10] = '{40'h00_0000_9001, 40'h00_0000_8002, 40'hFF_FFFF_8003,
                                40'hFF_FFFF_8004, 40'h00_8765_4321, 40'h00_0000_8006,
                                40'hFF_FFF8_0009, 40'h00_0009_8007, 40'h00_000F_8008,
                                40'hFF_FFF8_000A};

  core_register_file_latency dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i),
    .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_sel_i(rd_sel_i),
    .rd_idx_i(rd_idx_i), .pc_adv_i(pc_adv_i), .pc_load_i(pc_load_i),
    .pc_target_i(pc_target_i), .addr_base_i(addr_base_i), .step_sel_i(step_sel_i),
    .rd_data_o(rd_data_o), .rd_err_o(rd_err_o), .wr_err_o(wr_err_o),
    .cmd_valid_o(cmd_valid_o), .cmd_unit_o(cmd_unit_o), .cmd_data_o(cmd_data_o),
    .pc_o(pc_o), .next_addr_o(next_addr_o)
  );

  always #2 sys_clk_i = ~sys_clk_i;

  // whole run is a few hundred cycles, so this only trips on a hang
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // one request cycle; signals stay put until the next call changes them
  task automatic cyc(input logic w, input logic [4:0] ws, input logic [2:0] wi,
                     input logic [39:0] wd, input logic r, input logic [4:0] rs,
                     input logic [2:0] ri);
    @(posedge sys_clk_i);
    wr_en_i   <= w;
    wr_sel_i  <= ws;
    wr_idx_i  <= wi;
    wr_data_i <= wd;
    rd_en_i   <= r;
    rd_sel_i  <= rs;
    rd_idx_i  <= ri;
  endtask

  task automatic wr(input logic [4:0] s, input logic [2:0] i, input logic [39:0] d);
    cyc(1'b1, s, i, d, 1'b0, 5'h00, 3'h0);
  endtask

  task automatic rd(input logic [4:0] s, input logic [2:0] i);
    cyc(1'b0, 5'h00, 3'h0, 40'h00_0000_0000, 1'b1, s, i);
  endtask

  task automatic idle();
    cyc(1'b0, 5'h00, 3'h0, 40'h00_0000_0000, 1'b0, 5'h00, 3'h0);
  endtask

  // let the taking edge pass, then look at the registered outputs
  task automatic settle();
    idle();
    @(negedge sys_clk_i);
  endtask

  task automatic rd_chk(input string name, input logic [4:0] s, input logic [2:0] i,
                        input logic [39:0] e);
    rd(s, i);
    settle();
    check(name, e, rd_data_o);
  endtask

  // a read between write and readback must still return the older value
  task automatic lat(input logic [4:0] s, input logic [2:0] i, input logic [39:0] a,
                     input logic [39:0] b, input int n);
    wr(s, i, a);
    repeat (3) idle();
    wr(s, i, b);
    rd(s, i);
    for (int k = 1; k <= n + 1; k++) begin
      if (k <= n) rd(s, i);
      else idle();
      @(negedge sys_clk_i);
      check("latency read", (k <= n) ? a : b, rd_data_o);
    end
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int s = 0; s <= 24; s++) begin
      rd_chk("reset read", 5'(s), 3'h0, 40'h00_0000_0000);
    end
    check("pc_o", 40'h00_0000_0000, {20'h00000, pc_o});
    wr(SEL_ACC_FULL, 3'h3, 40'hA5_1234_8678);
    rd_chk("acc full", SEL_ACC_FULL, 3'h3, 40'hA5_1234_8678);
    rd_chk("acc high", SEL_ACC_HI, 3'h3, 40'h00_0000_1234);
    rd_chk("acc low", SEL_ACC_LO, 3'h3, 40'hFF_FFFF_8678);
    rd_chk("acc guard", SEL_ACC_GUARD, 3'h3, 40'hFF_FFFF_FFA5);
    wr(SEL_ACC_GUARD, 3'h3, 40'h00_0000_005A);
    rd_chk("acc after guard", SEL_ACC_FULL, 3'h3, 40'h5A_1234_8678);
    wr(SEL_ACC_VEC, 3'h1, 40'h00_8001_7FFE);
    rd_chk("vector lower acc", SEL_ACC_HI, 3'h2, 40'hFF_FFFF_8001);
    rd_chk("vector upper acc", SEL_ACC_FULL, 3'h3, 40'h5A_7FFE_8678);
    rd_chk("vector read", SEL_ACC_VEC, 3'h1, 40'hFF_8001_7FFE);
    wr(SEL_AUX, 3'h2, 40'h00_0000_8000);
    rd_chk("aux as data", SEL_AUX, 3'h2, 40'hFF_FFFF_8000);
    for (int r = 0; r < 10; r++) begin
      wr(reg_sel[r], 3'h1, reg_dat[r]);
      rd_chk("core register", reg_sel[r], 3'h1, reg_exp[r]);
    end
    rd_chk("pair index 0", SEL_AUC, 3'h0, 40'h00_0000_0000);
    wr(SEL_YSTEP_A, 3'h0, 40'h00_0008_A55A);
    rd_chk("y step", SEL_YSTEP_A, 3'h0, 40'hFF_FFF8_A55A);
    rd_chk("y high byte", SEL_YOFF_HB, 3'h0, 40'h00_0000_00A5);
    rd_chk("y low byte", SEL_YOFF_LB, 3'h0, 40'h00_0000_005A);
    wr(SEL_YOFF_HB, 3'h0, 40'h00_0000_00FF);
    settle();
    check("wr_err_o byte view", 40'h1, {39'h0, wr_err_o});
    rd_chk("y high byte kept", SEL_YOFF_HB, 3'h0, 40'h00_0000_00A5);
    wr(5'h1F, 3'h0, 40'h00_0000_1234);
    settle();
    check("wr_err_o unmapped", 40'h1, {39'h0, wr_err_o});
    rd_chk("unmapped read", 5'h1F, 3'h0, 40'h00_0000_0000);
    check("rd_err_o unmapped", 40'h1, {39'h0, rd_err_o});
    for (int u = 0; u < 2; u++) begin
      wr(SEL_IOCMD, 3'(u), 40'h00_0000_BEE0 + 40'(u));
      settle();
      check("cmd_valid_o", 40'h1, {39'h0, cmd_valid_o});
      check("cmd_unit_o", 40'(u), {39'h0, cmd_unit_o});
      check("cmd_data_o", 40'h00_0000_BEE0 + 40'(u), {24'h0, cmd_data_o});
      settle();
      check("cmd_valid_o end", 40'h0, {39'h0, cmd_valid_o});
    end
    rd_chk("command read", SEL_IOCMD, 3'h0, 40'h00_0000_0000);
    check("rd_err_o command", 40'h1, {39'h0, rd_err_o});
    settle();
    check("rd_err_o end", 40'h0, {39'h0, rd_err_o});
    lat(SEL_IOCFG, 3'h0, 40'h00_0000_8421, 40'h00_0000_1357, PERIPH_LAT);
    lat(SEL_MAILBOX, 3'h0, 40'h00_CAFE_0001, 40'h00_1234_ABCD, PERIPH_LAT);
    for (int p = 0; p < 2; p++) begin
      lat(SEL_IN_WPTR, 3'(p), 40'h00_0000_FFF0, 40'h00_0000_00AA, IOU_LAT);
      lat(SEL_OUT_RPTR, 3'(p), 40'h00_0000_8001, 40'h00_0000_1234, IOU_LAT);
    end
    @(posedge sys_clk_i);
    pc_adv_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    pc_adv_i <= 1'b0;
    @(negedge sys_clk_i);
    check("pc_o advance", 40'h3, {20'h00000, pc_o});
    @(posedge sys_clk_i);
    pc_load_i   <= 1'b1;
    pc_adv_i    <= 1'b1;
    pc_target_i <= 20'hFFFFF;
    @(posedge sys_clk_i);
    pc_load_i <= 1'b0;
    pc_adv_i  <= 1'b0;
    @(negedge sys_clk_i);
    check("pc_o load", 40'hF_FFFF, {20'h00000, pc_o});
    wr(SEL_XSTEP_A, 3'h0, 40'h00_000F_FFFE);
    wr(SEL_XSTEP_B, 3'h0, 40'h00_0000_0005);
    wr(SEL_YSTEP_B, 3'h0, 40'h00_0000_0001);
    idle();
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk_i);
      step_sel_i <= 2'(s);
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check("next_addr_o", {20'h00000, addr_exp[s]}, {20'h00000, next_addr_o});
    end
    idle();
    print_verdict();
  end
endmodule // test_core_register_file_latency
